/* testbench/mta_apb_host.sv */
// APB host model that issues one register transfer at a time.
`timescale 1ns/1ns
module mta_apb_host
    import mta_pkg::*;
(
    // Clock.
    input wire logic sys_clk,
    // APB master side.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [PADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
    end

    // Waits for the next edge first, so a release and a new setup never share a time step.
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic hung);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        hung = (n >= 20);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines are scrambled so a stale address or data word is never mistaken for a live one.
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the MAC table manual access block.
`timescale 1ns/1ns
module tb_top;
    import mta_pkg::*;
    logic sys_clk;
    logic resetn;
    logic psel, penable, pwrite, pready, pslverr, err, hung;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [31:0] seed = 32'h2362;
    logic [31:0] m_lo [TBL_DEPTH];
    logic [31:0] m_hi [TBL_DEPTH];
    logic [31:0] klo [6];
    logic [31:0] khi [6];
    int ptr;
    int fail_count = 0;
    int checks = 0;

    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    mta_top i_dut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
    mta_apb_host i_host (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        i_host.xfer(wr, idx, wd, rd, err, hung);
        if (hung) begin
            fail_count++;
            $display("CHECK FAILED pready expected 1 seen 0");
            conclude();
        end
    endtask

    task automatic rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        check(what, exp, rd);
    endtask

    // Polls pending under a bound; status stays in rd for the caller.
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, IDX_STATUS, 32'h0000_0000);
            n++;
        end while (rd[STS_PEND_BIT] !== 1'b0 && n < 40);
        if (n >= 40) begin
            fail_count++;
            $display("CHECK FAILED pending expected 0 seen 1");
            conclude();
        end
    endtask

    task automatic make(input logic [31:0] lo, input logic [31:0] hi, input bit poke);
        int k;
        logic full;
        k = -1;
        for (int i = 0; i < TBL_DEPTH; i++)
            if (k < 0 && m_hi[i][VALID_BIT] && m_lo[i] == lo && m_hi[i][15:0] == hi[15:0]) k = i;
        if (k < 0 && hi[VALID_BIT])
            for (int i = 0; i < TBL_DEPTH; i++)
                if (k < 0 && !m_hi[i][VALID_BIT]) k = i;
        if (k >= 0) begin
            m_lo[k] = lo;
            m_hi[k] = hi;
        end
        full = (k < 0) && hi[VALID_BIT];
        bus(1'b1, IDX_WR_LO, lo);
        bus(1'b1, IDX_WR_HI, hi);
        bus(1'b1, IDX_CMD, {29'h0000_0000, CMD_MAKE});
        if (poke) begin
            bus(1'b1, IDX_CMD, 32'h0000_0000);
            rdchk("command while busy", IDX_CMD, {29'h0000_0000, CMD_MAKE});
            bus(1'b0, IDX_STATUS, 32'h0000_0000);
            check("pending", 32'h0000_0001, {31'h0000_0000, rd[STS_PEND_BIT]});
        end
        wait_idle();
        check("table full", {31'h0000_0000, full}, {31'h0000_0000, rd[STS_FULL_BIT]});
    endtask

    task automatic lookup(input logic [CMD_W-1:0] c);
        int j;
        logic [31:0] elo, ehi;
        if (c == CMD_FIRST) ptr = 0;
        j = ptr;
        while (j < TBL_DEPTH && !m_hi[j][VALID_BIT]) j++;
        elo = (j < TBL_DEPTH) ? m_lo[j] : 32'h0000_0000;
        ehi = (j < TBL_DEPTH) ? m_hi[j] : 32'h0000_0000;
        ptr = (j < TBL_DEPTH) ? j + 1 : TBL_DEPTH;
        bus(1'b1, IDX_CMD, {29'h0000_0000, c});
        wait_idle();
        check("end of table", {31'h0000_0000, j >= TBL_DEPTH}, {31'h0000_0000, rd[STS_END_BIT]});
        rdchk("command after finish", IDX_CMD, 32'h0000_0000);
        rdchk("read low", IDX_RD_LO, elo);
        rdchk("read high", IDX_RD_HI, ehi);
    endtask

    task automatic scan(input int nexts);
        lookup(CMD_FIRST);
        repeat (nexts) lookup(CMD_NEXT);
    endtask

    initial begin
        resetn = 1'b0;
        ptr = 0;
        for (int i = 0; i < TBL_DEPTH; i++) begin
            m_lo[i] = 32'h0000_0000;
            m_hi[i] = 32'h0000_0000;
        end
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        rdchk("write low reset", IDX_WR_LO, WR_LO_RST);
        rdchk("write high reset", IDX_WR_HI, 32'h0000_0000);
        rdchk("status reset", IDX_STATUS, 32'h0000_0000);
        rdchk("read low reset", IDX_RD_LO, RD_RST);
        bus(1'b0, 16'h1805, 32'h0000_0000);
        check("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
        bus(1'b1, IDX_CMD, 32'h0000_0000);
        rdchk("zero command idle", IDX_STATUS, 32'h0000_0000);
        $display("test reset values done");
        v = rnd();
        bus(1'b1, IDX_WR_LO, v);
        rdchk("write low", IDX_WR_LO, v);
        v = rnd();
        bus(1'b1, IDX_WR_HI, v);
        rdchk("write high", IDX_WR_HI, v & 32'h07FF_FFFF);
        lookup(CMD_FIRST);
        $display("test empty table done");
        for (int i = 0; i < 6; i++) begin
            klo[i] = rnd();
            khi[i] = (rnd() & 32'h03FF_FFFF) | 32'h0400_0000;
            make(klo[i], khi[i], 1'b0);
        end
        scan(7);
        $display("test fill and scan done");
        make(klo[2], khi[2] ^ 32'h00F0_0000, 1'b0);
        make(klo[4], khi[4] & 32'h03FF_FFFF, 1'b0);
        scan(6);
        $display("test modify and remove done");
        make(rnd(), (rnd() & 32'h03FF_FFFF) | 32'h0400_0000, 1'b1);
        scan(7);
        $display("test zero write while busy done");
        for (int i = 0; i < 11; i++) begin
            make(rnd(), (rnd() & 32'h03FF_FFFF) | 32'h0400_0000, 1'b0);
        end
        $display("test table full done");
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        ptr = 0;
        for (int i = 0; i < TBL_DEPTH; i++) begin
            m_lo[i] = 32'h0000_0000;
            m_hi[i] = 32'h0000_0000;
        end
        rdchk("status after reset", IDX_STATUS, 32'h0000_0000);
        lookup(CMD_FIRST);
        $display("test reset in run done");
        conclude();
    end
endmodule

/* verilog/mta_entry_mem.sv */
// Entry store of the MAC lookup table; read and write share one address port.
`timescale 1ns/1ns
module mta_entry_mem
    import mta_pkg::*;
(
    // Clock and reset.
    input logic sys_clk,
    input logic resetn,
    // Table port.
    mta_mem_if.store port
);
    logic [ENTRY_W-1:0] entry_r [TBL_DEPTH];

    // Read is combinational so that the scan checks one entry per cycle.
    assign port.rdata = entry_r[port.addr];

    // Every entry is cleared at reset so that no stale entry reads as valid.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < TBL_DEPTH; i++) begin
                entry_r[i] <= '0;
            end
        end else if (port.we) begin
            entry_r[port.addr] <= port.wdata;
        end
    end
endmodule

/* verilog/mta_key_match.sv */
// Compares one table entry against the staged MAC address.
`timescale 1ns/1ns
module mta_key_match
    import mta_pkg::*;
(
    // Entry under test and staged key.
    input logic [ENTRY_W-1:0] entry,
    input logic [ENTRY_W-1:0] key,
    // Result.
    output logic live,
    output logic hit
);
    // The low word carries the leading 32 address bits, bit 0 the multicast bit.
    wire [MAC_W-1:0] entry_mac = {entry[LO_W +: MAC_HI_W], entry[LO_W-1:0]};
    wire [MAC_W-1:0] key_mac = {key[LO_W +: MAC_HI_W], key[LO_W-1:0]};

    assign live = entry[LO_W + VALID_BIT];
    assign hit = live && (entry_mac == key_mac);
endmodule

/* verilog/mta_mem_if.sv */
// Port between the command logic and the entry store.
`timescale 1ns/1ns
interface mta_mem_if;
    import mta_pkg::*;
    logic [TBL_AW-1:0] addr;
    logic we;
    logic [ENTRY_W-1:0] wdata;
    logic [ENTRY_W-1:0] rdata;
    modport ctrl (output addr, output we, output wdata, input rdata);
    modport store (input addr, input we, input wdata, output rdata);
endinterface

/* verilog/mta_pkg.sv */
// Shared constants and types of the MAC table manual access block.
package mta_pkg;
    // Register indexes; byte address on the bus is four times the index.
    localparam logic [15:0] IDX_CMD = 16'h1800;
    localparam logic [15:0] IDX_WR_LO = 16'h1801;
    localparam logic [15:0] IDX_WR_HI = 16'h1802;
    localparam logic [15:0] IDX_STATUS = 16'h1810;
    localparam logic [15:0] IDX_RD_LO = 16'h1811;
    localparam logic [15:0] IDX_RD_HI = 16'h1812;
    localparam int PADDR_W = 18;
    // Command register encodings, one bit per command.
    localparam int CMD_W = 3;
    localparam logic [CMD_W-1:0] CMD_NEXT = 3'h1;
    localparam logic [CMD_W-1:0] CMD_FIRST = 3'h2;
    localparam logic [CMD_W-1:0] CMD_MAKE = 3'h4;
    localparam logic [CMD_W-1:0] CMD_RST = 3'h0;
    // Status register field positions.
    localparam int STS_PEND_BIT = 0;
    localparam int STS_END_BIT = 1;
    localparam int STS_FULL_BIT = 2;
    // Entry layout: low word holds the first 32 MAC bits, high word the rest.
    localparam int LO_W = 32;
    localparam int HI_W = 27;
    localparam int VALID_BIT = 26;
    localparam int MAC_HI_W = 16;
    localparam int MAC_W = LO_W + MAC_HI_W;
    localparam int ENTRY_W = 64;
    localparam logic [LO_W-1:0] WR_LO_RST = 32'h0000_0000;
    localparam logic [HI_W-1:0] WR_HI_RST = 27'h000_0000;
    localparam logic [31:0] RD_RST = 32'h0000_0000;
    // Table size.
    localparam int TBL_DEPTH = 16;
    localparam int TBL_AW = 4;
    localparam int PTR_W = TBL_AW + 1;
    typedef enum {ST_IDLE, ST_SCAN, ST_WRITE, ST_DONE} mta_state_type;
endpackage

/* verilog/mta_top.sv */
// MAC table manual access: command interpreter with its APB register slave.
`timescale 1ns/1ns

// How it works
// - A one written to any command bit raises pending and starts that command.
// - Pending drops once a lookup entry is fetched; software then reads both words.
// - Make stores the staged write words (32 low bits plus 27 high bits) at a location the table picks.
// - Make also changes or removes an existing entry matched by MAC address.
// - Command bits self-clear in the same cycle pending falls.
// - Zero writes do nothing and never disturb a running command.
// - Get first resets the read pointer and loads the first valid entry.
// - Get next loads the first valid entry at or after the read pointer.
// - First write word holds the leading 32 MAC bits; bit 0 is multicast.
// - Second write word bit 26 marks valid; clear invalidates a matching entry.
module mta_top
    import mta_pkg::*;
(
    // Clock and reset.
    input logic sys_clk,
    input logic resetn,
    // APB slave.
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [PADDR_W-1:0] paddr,
    input logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);
    // A lookup ends three edges after its command at the soonest, and after a whole-table scan at the latest.
    localparam int LOOKUP_MIN = 3;
    localparam int LOOKUP_MAX = 19;

    mta_state_type state_r;
    logic [CMD_W-1:0] cmd_r;
    logic pend_r;
    logic end_r;
    logic full_r;
    logic [LO_W-1:0] wr_lo_r;
    logic [HI_W-1:0] wr_hi_r;
    logic [31:0] rd_lo_r;
    logic [31:0] rd_hi_r;
    logic [PTR_W-1:0] ptr_r;
    logic [PTR_W-1:0] scan_r;
    logic [PTR_W-1:0] hit_idx_r;
    logic [PTR_W-1:0] free_idx_r;
    logic hit_found_r;
    logic free_found_r;
    logic entry_live;
    logic entry_hit;
    logic [31:0] sts_word;

    mta_mem_if tbl ();

    // Address decode; misaligned or unknown addresses answer with an error.
    wire [15:0] reg_idx = paddr[PADDR_W-1:2];
    wire aligned = (paddr[1:0] == 2'h0);
    wire sel_cmd = aligned && (reg_idx == IDX_CMD);
    wire sel_wr_lo = aligned && (reg_idx == IDX_WR_LO);
    wire sel_wr_hi = aligned && (reg_idx == IDX_WR_HI);
    wire sel_sts = aligned && (reg_idx == IDX_STATUS);
    wire sel_rd_lo = aligned && (reg_idx == IDX_RD_LO);
    wire sel_rd_hi = aligned && (reg_idx == IDX_RD_HI);
    wire mapped = sel_cmd || sel_wr_lo || sel_wr_hi || sel_sts || sel_rd_lo || sel_rd_hi;
    wire setup = psel && !penable;
    wire wr_go = psel && penable && pready && pwrite;

    // Command acceptance.
    wire [CMD_W-1:0] cmd_in = pwdata[CMD_W-1:0];
    wire cmd_wr = wr_go && sel_cmd;
    wire accept = cmd_wr && (cmd_in != CMD_RST) && !pend_r;
    // Several bits at once are resolved make first, then first, then next.
    wire [CMD_W-1:0] cmd_pick = cmd_in[2] ? CMD_MAKE : (cmd_in[1] ? CMD_FIRST : CMD_NEXT);

    // Scan and write decisions.
    wire is_make = (cmd_r == CMD_MAKE);
    wire at_end = (scan_r == PTR_W'(TBL_DEPTH));
    wire [PTR_W-1:0] scan_inc = scan_r + 1'b1;
    wire [ENTRY_W-1:0] make_key = {32'(wr_hi_r), wr_lo_r};
    wire new_valid = wr_hi_r[VALID_BIT];
    // A matching entry is overwritten, which also removes it when valid is clear.
    wire write_ok = hit_found_r || (new_valid && free_found_r);
    wire [PTR_W-1:0] target = hit_found_r ? hit_idx_r : free_idx_r;
    wire in_write = (state_r == ST_WRITE);
    wire in_scan = (state_r == ST_SCAN);
    wire lookup_load = in_scan && !is_make && (at_end || entry_live);

    assign tbl.addr = in_write ? target[TBL_AW-1:0] : scan_r[TBL_AW-1:0];
    assign tbl.we = in_write && write_ok;
    assign tbl.wdata = make_key;

    mta_entry_mem u_mem (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .port(tbl.store)
    );

    mta_key_match u_match (
        .entry(tbl.rdata),
        .key(make_key),
        .live(entry_live),
        .hit(entry_hit)
    );

    always_comb begin
        sts_word = '0;
        sts_word[STS_PEND_BIT] = pend_r;
        sts_word[STS_END_BIT] = end_r;
        sts_word[STS_FULL_BIT] = full_r;
    end

    // Command bits read back as set until the command finishes.
    wire [31:0] rd_mux =
        sel_cmd ? 32'(cmd_r) :
        sel_wr_lo ? wr_lo_r :
        sel_wr_hi ? 32'(wr_hi_r) :
        sel_sts ? sts_word :
        sel_rd_lo ? rd_lo_r :
        sel_rd_hi ? rd_hi_r : RD_RST;

    // Read data is captured in the setup cycle so every answer has no wait state.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pready <= 1'b0;
            prdata <= RD_RST;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= rd_mux;
                pslverr <= !mapped;
            end
        end
    end

    // Staging words; the reserved top bits of the high word are not stored.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wr_lo_r <= WR_LO_RST;
            wr_hi_r <= WR_HI_RST;
        end else begin
            if (wr_go && sel_wr_lo) begin
                wr_lo_r <= pwdata;
            end
            if (wr_go && sel_wr_hi) begin
                wr_hi_r <= pwdata[HI_W-1:0];
            end
        end
    end

    // Command sequencer; one table entry is examined per cycle.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cmd_r <= CMD_RST;
            pend_r <= 1'b0;
            end_r <= 1'b0;
            full_r <= 1'b0;
            ptr_r <= '0;
            scan_r <= '0;
            hit_idx_r <= '0;
            free_idx_r <= '0;
            hit_found_r <= 1'b0;
            free_found_r <= 1'b0;
            rd_lo_r <= RD_RST;
            rd_hi_r <= RD_RST;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (accept) begin
                        cmd_r <= cmd_pick;
                        pend_r <= 1'b1;
                        hit_found_r <= 1'b0;
                        free_found_r <= 1'b0;
                        state_r <= ST_SCAN;
                        if (cmd_pick == CMD_NEXT) begin
                            scan_r <= ptr_r;
                        end else begin
                            scan_r <= '0;
                        end
                        if (cmd_pick == CMD_FIRST) begin
                            ptr_r <= '0;
                        end
                    end
                end
                ST_SCAN: begin
                    // Make always walks the whole table, because a match may sit after the first free slot.
                    if (is_make) begin
                        if (at_end) begin
                            state_r <= ST_WRITE;
                        end else begin
                            if (entry_hit && !hit_found_r) begin
                                hit_found_r <= 1'b1;
                                hit_idx_r <= scan_r;
                            end
                            if (!entry_live && !free_found_r) begin
                                free_found_r <= 1'b1;
                                free_idx_r <= scan_r;
                            end
                            scan_r <= scan_inc;
                        end
                    end else if (at_end) begin
                        // No valid entry left: read words show an invalid entry.
                        rd_lo_r <= RD_RST;
                        rd_hi_r <= RD_RST;
                        end_r <= 1'b1;
                        ptr_r <= scan_r;
                        state_r <= ST_DONE;
                    end else if (entry_live) begin
                        rd_lo_r <= tbl.rdata[31:0];
                        rd_hi_r <= tbl.rdata[ENTRY_W-1:32];
                        end_r <= 1'b0;
                        ptr_r <= scan_inc;
                        state_r <= ST_DONE;
                    end else begin
                        scan_r <= scan_inc;
                    end
                end
                ST_WRITE: begin
                    // A valid entry with no match and no free slot is dropped.
                    full_r <= new_valid && !write_ok;
                    state_r <= ST_DONE;
                end
                ST_DONE: begin
                    cmd_r <= CMD_RST;
                    pend_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                    cmd_r <= CMD_RST;
                    pend_r <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_cmd_go;
        accept;
    endsequence

    sequence s_lookup_go;
        accept && (cmd_pick != CMD_MAKE);
    endsequence

    sequence s_make_go;
        accept && (cmd_pick == CMD_MAKE);
    endsequence

    sequence s_first_go;
        accept && (cmd_pick == CMD_FIRST);
    endsequence

    sequence s_next_go;
        accept && (cmd_pick == CMD_NEXT);
    endsequence

    sequence s_end_load;
        lookup_load && at_end;
    endsequence

    a_pend_rise:
    assert property (s_cmd_go |=> pend_r && (cmd_r == $past(cmd_pick)))
        else $error("pending or command bit not raised after command write");

    a_lookup_done:
    assert property (s_lookup_go |-> ##[LOOKUP_MIN:LOOKUP_MAX] !pend_r)
        else $error("lookup command did not complete in time");

    a_make_timing:
    assert property (s_make_go |-> ##19 pend_r ##1 !pend_r)
        else $error("make command did not take the full table scan");

    a_make_data:
    assert property (tbl.we |-> in_write && (tbl.wdata == {32'(wr_hi_r), wr_lo_r}) ##1 !tbl.we)
        else $error("table write carries wrong data or lasts too long");

    a_make_match:
    assert property ((in_write && hit_found_r) |-> tbl.we && (tbl.addr == hit_idx_r[TBL_AW-1:0]))
        else $error("make did not overwrite the matching entry");

    a_cmd_clear:
    assert property ($fell(pend_r) |-> (cmd_r == CMD_RST) && ($past(cmd_r) != CMD_RST))
        else $error("command bit not cleared together with pending");

    a_cmd_onehot:
    assert property (pend_r |-> $onehot(cmd_r))
        else $error("command bits not one-hot while pending");

    a_busy_ignore:
    assert property ((cmd_wr && pend_r && (state_r != ST_DONE)) |=> pend_r && $stable(cmd_r))
        else $error("command write disturbed a running command");

    a_first_ptr:
    assert property (s_first_go |=> (ptr_r == '0) && (scan_r == '0))
        else $error("get first did not restart at the table start");

    a_next_load:
    assert property ((lookup_load && !at_end) |=> (rd_lo_r == $past(tbl.rdata[31:0])) && (ptr_r == $past(scan_inc)))
        else $error("lookup did not load the entry or advance the pointer");

    a_invalid_nomatch:
    assert property ((in_write && !new_valid && !hit_found_r) |-> !tbl.we)
        else $error("invalid make without a match wrote the table");

    a_rd_hold:
    assert property (!lookup_load |=> $stable(rd_lo_r) && $stable(rd_hi_r))
        else $error("read words changed without a completed lookup");

    // The checks below look one edge after the decision, where the registered result stands.
    a_full_flag:
    assert property (in_write |=> (full_r == $past(new_valid && !write_ok)))
        else $error("table full flag does not match the make outcome");

    a_end_flag:
    assert property (s_end_load |=> end_r && (rd_lo_r == RD_RST) && (rd_hi_r == RD_RST) && (ptr_r == PTR_W'(TBL_DEPTH)))
        else $error("end of table not reported with cleared read words");

    a_next_start:
    assert property (s_next_go |=> (scan_r == $past(ptr_r)))
        else $error("get next did not start at the read pointer");

    a_make_keep_ptr:
    assert property ((pend_r && is_make) |=> $stable(ptr_r))
        else $error("make moved the read pointer");

    a_zero_write:
    assert property ((cmd_wr && (cmd_in == CMD_RST) && !pend_r) |=> !pend_r && (cmd_r == CMD_RST))
        else $error("zero command write started a command");

    a_stage_low:
    assert property ((wr_go && sel_wr_lo) |=> (wr_lo_r == $past(pwdata)))
        else $error("first write word not stored");
endmodule
